/* adc_scan_regs.svh */
// Summary of operation
// - Scan converts channels zero upward to the selected one
// - Each result stored when its conversion ends
// - Last channel done: set flag, clear go unless repeating
// - Done flag set by hardware, cleared by zero
// - Irq enable makes done flag request interrupt
// - Mode bit one selects scan of channel group
// - Channel select picks inputs; in scan mode three covers all
// - Trigger enable zero ignores external triggers
// - Clock select divides clock; zero gives 32
// - Writing go one starts a conversion sequence
// - Writing go zero abandons running conversion
// - Repeat zero: one pass per start, then halt
// - Sleep bit one holds converter stopped
// - Four read-only results, one per input
// - Result in bits 15..6, low six zero
`ifndef ADC_SCAN_REGS_SVH
`define ADC_SCAN_REGS_SVH

// Register byte addresses
`define OFS_MODULE_SLEEP_CTRL 8'h00
`define OFS_CONV_CTRL_STATUS 8'h04
`define OFS_CONV_CONTROL 8'h08
`define OFS_RESULT_CH0 8'h0c
`define OFS_RESULT_CH1 8'h10
`define OFS_RESULT_CH2 8'h14
`define OFS_RESULT_CH3 8'h18
`define OFS_IRQ_STATUS 8'h1c
`define OFS_IRQ_ENABLE 8'h20
`define OFS_IRQ_CLEAR 8'h24

// Field positions
`define BIT_CONVERTER_SLEEP 4
`define BIT_SCAN_DONE_FLAG 7
`define BIT_DONE_IRQ_ENABLE 6
`define BIT_SCAN_MODE_SELECT 4
`define BIT_EXT_TRIGGER_ENABLE 7
`define BIT_CLOCK_SEL_LO 5
`define BIT_CONVERSION_GO 4
`define BIT_REPEAT_SCAN 3
`define BIT_EVT_DONE 0
`define BIT_EVT_ABORT 1
`define RESULT_LSB 6

// Reset values and fixed reserved bits
`define MODULE_SLEEP_RESET 16'hffff
`define CTRL_RESERVED_FIXED 3'h7

// Conversion clock dividers minus one
`define DIV_32_M1 5'h1f
`define DIV_16_M1 5'h0f
`define DIV_8_M1 5'h07
`define DIV_4_M1 5'h03

// Divided ticks per conversion
`define CONV_TICKS 4'ha

`endif

/* adc_scan_pkg.sv */
package adc_scan_pkg;

   // Sequencer states, Gray coded along idle, launch, convert
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_LAUNCH = 2'b01,
      ST_CONVERT = 2'b11
   } seq_state_e;

endpackage

/* adc_single_scan_control.sv */
`include "adc_scan_regs.svh"

module adc_single_scan_control #(
   parameter int RESULT_W = 10,
   parameter logic [3:0] CONV_TICKS = `CONV_TICKS
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External trigger pin
   input wire logic ext_trigger,
   // Conversion core
   output logic [1:0] sample_channel,
   output logic sample_start,
   output logic conv_clk_en,
   input wire logic [RESULT_W-1:0] conv_result,
   // Interrupt
   output logic irq
);

   // Software visible state
   logic [15:0] module_sleep_ctrl;
   logic scan_done_flag;
   logic done_irq_enable;
   logic scan_mode_select;
   logic [1:0] channel_select;
   logic external_trigger_enable;
   logic [1:0] conv_clock_sel;
   logic conversion_go;
   logic repeat_scan;
   logic [15:0] result_reg [4];
   logic [1:0] irq_status;
   logic [1:0] irq_enable;

   // Sequencer state
   adc_scan_pkg::seq_state_e state;
   logic [1:0] channel;
   logic [4:0] div_cnt;
   logic [4:0] div_max;
   logic div_tick;
   logic [3:0] tick_cnt;
   logic conv_end;
   logic last_channel;
   logic [1:0] first_channel;
   logic [1:0] final_channel;

   // Bus decode
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic wr_sleep;
   logic wr_status;
   logic wr_ctrl;
   logic wr_irq_en;
   logic wr_irq_clr;

   // Trigger synchroniser
   logic trig_s1;
   logic trig_s2;
   logic trig_s3;
   logic trig_level;
   logic trig_rise;

   // Start and stop causes
   logic sleeping;
   logic sw_start;
   logic sw_stop;
   logic hw_start;
   logic start_req;
   logic abort;
   logic scan_finish;

   // Address decode and strobes
   always_comb
   begin
      unique case (paddr)
         `OFS_MODULE_SLEEP_CTRL, `OFS_CONV_CTRL_STATUS, `OFS_CONV_CONTROL,
         `OFS_RESULT_CH0, `OFS_RESULT_CH1, `OFS_RESULT_CH2, `OFS_RESULT_CH3,
         `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE, `OFS_IRQ_CLEAR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign wr_sleep = wr_en && (paddr == `OFS_MODULE_SLEEP_CTRL);
   assign wr_status = wr_en && (paddr == `OFS_CONV_CTRL_STATUS);
   assign wr_ctrl = wr_en && (paddr == `OFS_CONV_CONTROL);
   assign wr_irq_en = wr_en && (paddr == `OFS_IRQ_ENABLE);
   assign wr_irq_clr = wr_en && (paddr == `OFS_IRQ_CLEAR);

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Read data captured in the setup phase
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
      begin
         unique case (paddr)
            `OFS_MODULE_SLEEP_CTRL: prdata <= {16'h0000, module_sleep_ctrl};
            `OFS_CONV_CTRL_STATUS: prdata <= {24'h00_0000, scan_done_flag,
               done_irq_enable, 1'b0, scan_mode_select, 2'b00,
               channel_select};
            `OFS_CONV_CONTROL: prdata <= {24'h00_0000, external_trigger_enable,
               conv_clock_sel, conversion_go, repeat_scan,
               `CTRL_RESERVED_FIXED};
            `OFS_RESULT_CH0: prdata <= {16'h0000, result_reg[0]};
            `OFS_RESULT_CH1: prdata <= {16'h0000, result_reg[1]};
            `OFS_RESULT_CH2: prdata <= {16'h0000, result_reg[2]};
            `OFS_RESULT_CH3: prdata <= {16'h0000, result_reg[3]};
            `OFS_IRQ_STATUS: prdata <= {30'h0000_0000, irq_status};
            `OFS_IRQ_ENABLE: prdata <= {30'h0000_0000, irq_enable};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Module sleep register; the converter bit gates all activity
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         module_sleep_ctrl <= `MODULE_SLEEP_RESET;
      else if (wr_sleep)
         module_sleep_ctrl <= pwdata[15:0];
   end

   assign sleeping = module_sleep_ctrl[`BIT_CONVERTER_SLEEP];

   // Control and status settings; reserved bits are not stored
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_irq_enable <= 1'b0;
         scan_mode_select <= 1'b0;
         channel_select <= 2'b00;
      end
      else if (wr_status)
      begin
         done_irq_enable <= pwdata[`BIT_DONE_IRQ_ENABLE];
         scan_mode_select <= pwdata[`BIT_SCAN_MODE_SELECT];
         channel_select <= pwdata[1:0];
      end
   end

   // Control register settings
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         external_trigger_enable <= 1'b0;
         conv_clock_sel <= 2'b00;
         repeat_scan <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         external_trigger_enable <= pwdata[`BIT_EXT_TRIGGER_ENABLE];
         conv_clock_sel <= pwdata[`BIT_CLOCK_SEL_LO+1:`BIT_CLOCK_SEL_LO];
         repeat_scan <= pwdata[`BIT_REPEAT_SCAN];
      end
   end

   // Trigger pin through three flops; level moves when two and three agree
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
         trig_level <= 1'b0;
      end
      else
      begin
         trig_s1 <= ext_trigger;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
         if (trig_s2 == trig_s3)
            trig_level <= trig_s3;
      end
   end

   assign trig_rise = (trig_s2 == trig_s3) && trig_s3 && !trig_level;

   // Start and abort causes
   assign sw_start = wr_ctrl && pwdata[`BIT_CONVERSION_GO];
   assign sw_stop = wr_ctrl && !pwdata[`BIT_CONVERSION_GO] && conversion_go;
   assign hw_start = external_trigger_enable && trig_rise;
   assign start_req = (sw_start || hw_start) && !conversion_go && !sleeping;
   assign abort = conversion_go && (sw_stop || sleeping);

   // Channel range: scan covers zero up to the selection, single is one
   assign first_channel = scan_mode_select ? 2'b00 : channel_select;
   assign final_channel = channel_select;
   assign last_channel = (channel == final_channel);

   // Conversion clock divider, free running only while converting
   always_comb
   begin
      unique case (conv_clock_sel)
         2'b00: div_max = `DIV_32_M1;
         2'b01: div_max = `DIV_16_M1;
         2'b10: div_max = `DIV_8_M1;
         2'b11: div_max = `DIV_4_M1;
      endcase
   end

   assign div_tick = (state == adc_scan_pkg::ST_CONVERT) && (div_cnt == div_max);
   assign conv_clk_en = div_tick;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         div_cnt <= 5'h00;
      else if (state != adc_scan_pkg::ST_CONVERT || div_tick)
         div_cnt <= 5'h00;
      else
         div_cnt <= div_cnt + 5'h01;
   end

   // Divided ticks that make up one conversion
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_cnt <= 4'h0;
      else if (state != adc_scan_pkg::ST_CONVERT)
         tick_cnt <= 4'h0;
      else if (div_tick)
         tick_cnt <= tick_cnt + 4'h1;
   end

   assign conv_end = div_tick && (tick_cnt == CONV_TICKS - 4'h1) && !abort;
   assign scan_finish = conv_end && last_channel;

   // Sequencer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= adc_scan_pkg::ST_IDLE;
         channel <= 2'b00;
      end
      else if (abort)
         state <= adc_scan_pkg::ST_IDLE;
      else
      begin
         unique case (state)
            adc_scan_pkg::ST_IDLE:
               if (start_req)
               begin
                  channel <= first_channel;
                  state <= adc_scan_pkg::ST_LAUNCH;
               end
            adc_scan_pkg::ST_LAUNCH:
               state <= adc_scan_pkg::ST_CONVERT;
            adc_scan_pkg::ST_CONVERT:
               if (conv_end)
               begin
                  state <= adc_scan_pkg::ST_LAUNCH;
                  if (!last_channel)
                     channel <= channel + 2'b01;
                  else if (repeat_scan)
                     channel <= first_channel;
                  else
                     state <= adc_scan_pkg::ST_IDLE;
               end
            default:
               state <= adc_scan_pkg::ST_IDLE;
         endcase
      end
   end

   assign sample_start = (state == adc_scan_pkg::ST_LAUNCH);
   assign sample_channel = channel;

   // Go bit doubles as busy; cleared at the end of a single pass
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         conversion_go <= 1'b0;
      else if (start_req)
         conversion_go <= 1'b1;
      else if (abort)
         conversion_go <= 1'b0;
      else if (scan_finish && !repeat_scan)
         conversion_go <= 1'b0;
   end

   // Result store, left aligned with six zero bits below
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 4; i++)
            result_reg[i] <= 16'h0000;
      end
      else if (conv_end)
         result_reg[channel] <= {conv_result, 6'h00};
   end

   // Done flag: hardware sets, software writes zero to clear, set wins
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         scan_done_flag <= 1'b0;
      else if (scan_finish)
         scan_done_flag <= 1'b1;
      else if (wr_status && !pwdata[`BIT_SCAN_DONE_FLAG])
         scan_done_flag <= 1'b0;
   end

   // Sticky event status, write one to clear, set wins over clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_status <= 2'b00;
      else
      begin
         if (scan_finish)
            irq_status[`BIT_EVT_DONE] <= 1'b1;
         else if (wr_irq_clr && pwdata[`BIT_EVT_DONE])
            irq_status[`BIT_EVT_DONE] <= 1'b0;
         if (abort)
            irq_status[`BIT_EVT_ABORT] <= 1'b1;
         else if (wr_irq_clr && pwdata[`BIT_EVT_ABORT])
            irq_status[`BIT_EVT_ABORT] <= 1'b0;
      end
   end

   // Interrupt enable register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_enable <= 2'b00;
      else if (wr_irq_en)
         irq_enable <= pwdata[1:0];
   end

   // One level interrupt line
   assign irq = (done_irq_enable && scan_done_flag) || (|(irq_status & irq_enable));

endmodule

/* adc_analog_model.sv */
module adc_analog_model (
   // Converter link
   input wire logic clk,
   input wire logic [1:0] sample_channel,
   input wire logic conv_clk_en,
   // Level set by the bench
   input wire logic [7:0] level,
   output logic [9:0] conv_result
);
   logic [9:0] noise = 10'h000;
   // Between samples the input keeps moving
   always @(posedge clk)
      noise <= noise + 10'h13d;
   // Each input shows its own level on a tick
   assign conv_result = conv_clk_en ? {sample_channel, level} : noise;
endmodule

/* adc_chk.sv */
module adc_chk (
   // Clock, reset and bus
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   // Converter side
   input wire logic ext_trigger,
   input wire logic [1:0] sample_channel,
   input wire logic sample_start,
   input wire logic conv_clk_en
);
   logic wr;
   logic awake;
   logic trg_on;
   logic seen;
   logic [1:0] sel;
   logic [5:0] gap;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Bus write decode
   assign wr = psel && penable && pwrite;
   // Settings written by software
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awake <= 1'b0;
         trg_on <= 1'b0;
         sel <= 2'h0;
      end
      else if (wr && paddr == 8'h00)
         awake <= !pwdata[4];
      else if (wr && paddr == 8'h08)
      begin
         trg_on <= pwdata[7];
         sel <= pwdata[6:5];
      end
   end
   // Cycles between ticks of one conversion
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap <= 6'h0;
         seen <= 1'b0;
      end
      else
      begin
         gap <= conv_clk_en ? 6'h1 : gap + 6'h1;
         seen <= conv_clk_en || (seen && !sample_start);
      end
   end
   sequence go_write;
      wr && paddr == 8'h08 && pwdata[4];
   endsequence
   sequence stop_write;
      wr && paddr == 8'h08 && !pwdata[4];
   endsequence
   start_ch0_a: assert property (go_write ##1 sample_start |-> sample_channel == 2'h0)
      else $error("scan did not begin at channel 0");
   chan_step_a: assert property (sample_start && sample_channel != 2'h0 |->
      $past(sample_channel) == sample_channel - 2'h1) else $error("channel order broken");
   start_pulse_a: assert property (sample_start |=>
      !sample_start && $stable(sample_channel)) else $error("start pulse too long");
   abort_stop_a: assert property (stop_write |=>
      (!sample_start && !conv_clk_en) [*2]) else $error("conversion kept running");
   sleep_quiet_a: assert property (!awake |-> !sample_start && !conv_clk_en)
      else $error("converter ran while asleep");
   trig_ignore_a: assert property (!trg_on && $rose(ext_trigger) |=> !sample_start [*4])
      else $error("disabled trigger started a scan");
   tick_gap_a: assert property (conv_clk_en && seen |-> gap == (6'h20 >> sel))
      else $error("wrong conversion clock divider");
   error_resp_a: assert property (psel && penable |->
      pslverr == (paddr > 8'h24 || paddr[1:0] != 2'h0))
      else $error("wrong error response");
endmodule

bind adc_single_scan_control adc_chk chk (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .ext_trigger(ext_trigger), .sample_channel(sample_channel),
   .sample_start(sample_start), .conv_clk_en(conv_clk_en));

/* test_adc_single_scan_control.sv */
module test_adc_single_scan_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, ext_trigger, pready, pslverr;
   logic sample_start, conv_clk_en, irq;
   logic [7:0] paddr, level;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] sample_channel;
   logic [9:0] conv_result;
   logic [31:0] err_seen;
   int num_errors, total_checks, cycles;

   adc_single_scan_control #(.CONV_TICKS(4'h2)) uut (.clk(clk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_trigger(ext_trigger),
      .sample_channel(sample_channel), .sample_start(sample_start),
      .conv_clk_en(conv_clk_en), .conv_result(conv_result), .irq(irq));
   adc_analog_model model (.clk(clk), .sample_channel(sample_channel),
      .conv_clk_en(conv_clk_en), .level(level), .conv_result(conv_result));

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         num_errors++;
         conclude();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer, then an idle cycle
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err_seen = 32'(pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task wait_done();
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[7] !== 1'b1 && n < 500)
      begin
         xfer(1'b0, 8'h04, 32'h0);
         n++;
      end
   endtask

   task t_reset();
      xfer(1'b0, 8'h00, 32'h0);
      check(rd, 32'hffff);
      xfer(1'b0, 8'h04, 32'h0);
      check(rd, 32'h0);
      xfer(1'b0, 8'h08, 32'h0);
      check(rd, 32'h7);
      xfer(1'b1, 8'h08, 32'h17);
      xfer(1'b0, 8'h08, 32'h0);
      check(rd, 32'h7);
      xfer(1'b1, 8'h30, 32'h0);
      check(err_seen, 32'h1);
      xfer(1'b1, 8'h0c, 32'hffff);
      xfer(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h0);
      xfer(1'b1, 8'h00, 32'hffef);
      xfer(1'b0, 8'h00, 32'h0);
      check(rd, 32'hffef);
      xfer(1'b1, 8'h04, 32'hff);
      xfer(1'b0, 8'h04, 32'h0);
      check(rd, 32'h53);
      $display("reset test done");
   endtask

   task t_scan();
      xfer(1'b1, 8'h08, 32'h17);
      xfer(1'b0, 8'h08, 32'h0);
      check(rd, 32'h17);
      wait_done();
      check(rd, 32'hd3);
      check(32'(irq), 32'h1);
      xfer(1'b0, 8'h08, 32'h0);
      check(rd, 32'h7);
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b0, 8'h0c + 8'(4 * i), 32'h0);
         check(rd, 32'({i[1:0], 8'h5a, 6'h0}));
      end
      xfer(1'b1, 8'h04, 32'hd3);
      xfer(1'b0, 8'h04, 32'h0);
      check(rd, 32'hd3);
      xfer(1'b1, 8'h04, 32'h53);
      xfer(1'b0, 8'h04, 32'h0);
      check(rd, 32'h53);
      check(32'(irq), 32'h0);
      $display("scan test done");
   endtask

   task t_single();
      level <= 8'h33;
      xfer(1'b1, 8'h04, 32'h0);
      xfer(1'b1, 8'h08, 32'h77);
      wait_done();
      xfer(1'b0, 8'h08, 32'h0);
      check(rd, 32'h67);
      xfer(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h0cc0);
      xfer(1'b0, 8'h10, 32'h0);
      check(rd, 32'h5680);
      xfer(1'b1, 8'h04, 32'h13);
      $display("single test done");
   endtask

   task t_abort();
      xfer(1'b1, 8'h08, 32'h37);
      repeat (40) @(posedge clk);
      xfer(1'b1, 8'h08, 32'h27);
      xfer(1'b0, 8'h08, 32'h0);
      check(rd, 32'h27);
      xfer(1'b0, 8'h04, 32'h0);
      check(rd, 32'h13);
      xfer(1'b0, 8'h1c, 32'h0);
      check(rd, 32'h3);
      xfer(1'b1, 8'h20, 32'h2);
      check(32'(irq), 32'h1);
      xfer(1'b1, 8'h20, 32'h0);
      check(32'(irq), 32'h0);
      xfer(1'b1, 8'h24, 32'h3);
      xfer(1'b0, 8'h1c, 32'h0);
      check(rd, 32'h0);
      $display("abort test done");
   endtask

   task t_trigger();
      ext_trigger <= 1'b1;
      repeat (10) @(posedge clk);
      ext_trigger <= 1'b0;
      xfer(1'b0, 8'h08, 32'h0);
      check(rd, 32'h27);
      xfer(1'b1, 8'h08, 32'h87);
      ext_trigger <= 1'b1;
      repeat (10) @(posedge clk);
      ext_trigger <= 1'b0;
      xfer(1'b0, 8'h08, 32'h0);
      check(rd, 32'h97);
      wait_done();
      check(rd, 32'h93);
      $display("trigger test done");
   endtask

   task conclude();
      $display("Checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_trigger = 1'b0;
      level = 8'h5a;
      num_errors = 0;
      total_checks = 0;
      cycles = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_scan();
      t_single();
      t_abort();
      t_trigger();
      conclude();
   end
endmodule
